/* File: design/flx_pkg.sv */
// Shared constants for the fault log and extremes block.
// Assumes one 10 MHz system clock and a PMBus front end that decodes commands.
package flx_pkg;
  // Command codes on the command port
  localparam logic [7:0] CMD_STORE = 8'hEA;
  localparam logic [7:0] CMD_RESTORE = 8'hEB;
  localparam logic [7:0] CMD_ERASE = 8'hEC;
  localparam logic [7:0] CMD_STATUS = 8'hED;
  localparam logic [7:0] CMD_BLOCK = 8'hEE;
  // Preset values of the high-water and low-water registers
  localparam logic [15:0] VOUT_PEAK_RST = 16'hF800;
  localparam logic [15:0] IOUT_PEAK_RST = 16'h7C00;
  localparam logic [15:0] TEMP_PEAK_RST = 16'h7C00;
  localparam logic [15:0] VIN_MIN_RST = 16'h7BFF;
  localparam logic [15:0] VOUT_MIN_RST = 16'hFFFF;
  localparam logic [15:0] IOUT_MIN_RST = 16'h7BFF;
  localparam logic [15:0] TEMP_MIN_RST = 16'h7BFF;
  // Status byte layout
  localparam int ST_EEP_BIT = 0;
  localparam int ST_RAM_BIT = 1;
  localparam logic [1:0] STATUS_RST = 2'h0;
  // Conversion kinds
  localparam logic [1:0] KIND_VOUT = 2'h0;
  localparam logic [1:0] KIND_IOUT = 2'h1;
  localparam logic [1:0] KIND_TEMP = 2'h2;
  localparam logic [1:0] KIND_VIN = 2'h3;
  // Log layout
  localparam int LOG_BYTES = 255;
  localparam logic [7:0] LAST_BYTE = 8'hFE;
  localparam logic [7:0] COPY_END = 8'hFF;
  localparam logic [7:0] POS_BYTE = 8'h00;
  localparam logic [7:0] CH0_BASE = 8'h0B;
  localparam logic [7:0] CH1_BASE = 8'h23;
  localparam logic [7:0] CH_BYTES = 8'h0C;
  localparam logic [7:0] VIN_MIN_LO = 8'h19;
  localparam logic [7:0] VIN_MIN_HI = 8'h1A;
  localparam logic [7:0] PRE_LAST = 8'h2E;
  localparam logic [7:0] RING_BASE = 8'h2F;
  localparam logic [6:0] RING_LAST = 7'h67;
  localparam logic [7:0] ERASE_VAL = 8'hFF;
  // Fast transfer deadline
  localparam longint CLK_HZ = 10000000;
  localparam longint FAST_LOG_MS = 24;
  localparam int FAST_LOG_CYC = int'(FAST_LOG_MS * CLK_HZ / 1000);
  // Transfer engine states
  typedef enum logic [2:0] {FLX_IDLE, FLX_WAIT, FLX_STORE, FLX_RESTORE, FLX_ERASE} flx_state_e;
endpackage

/* File: design/flx_mem.sv */
// Byte memory with one write port and one registered read port.
// Assumes write and read on the same clock; read data appear one edge after the address.
`timescale 1ns/1ps
module flx_mem #(
  parameter int DEPTH = 255,
  parameter int AW = 8
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [7:0] rdata_r
);
  logic [7:0] mem [DEPTH];

  // Storage and registered read
  always_ff @(posedge sys_clk) begin
    if (we && (int'(waddr) < DEPTH)) begin
      mem[waddr] <= wdata;
    end
    rdata_r <= (int'(raddr) < DEPTH) ? mem[raddr] : 8'h00;
  end
endmodule

/* File: design/flx_fault_log.sv */
// Fault log controller with per-channel high-water and low-water telemetry.
// Assumes a PMBus front end on sys_clk that decodes command codes into strobes, and ADC results
// and channel states coming from logic on the same clock.
// Function
// R1 - Keep per-channel peak output voltage, preset F800 on reset, clear, turn-on.
// R2 - Keep per-channel peak output current, preset 7C00 on reset, clear, turn-on.
// R3 - Keep per-channel peak diode temperature, preset 7C00 on reset, clear, turn-on.
// R4 - Keep shared minimum input voltage, preset 7BFF on reset, any clear, any turn-on.
// R5 - Keep per-channel minimum output voltage, preset FFFF on reset, clear, turn-on.
// R6 - Keep per-channel minimum output current, preset 7BFF on reset, clear, turn-on.
// R7 - Keep per-channel minimum diode temperature, preset 7BFF on reset, clear, turn-on.
// R8 - Command EA copies the log buffer into nonvolatile storage.
// R9 - Command EB restores storage into buffer and locks it until a full read.
// R10 - Command EC erases storage and re-enables logging; host checks lock first.
// R11 - Read byte ED returns status; read block EE returns log bytes in order.
// R12 - Buffer continuously refreshed with readings and their extremes.
// R13 - A fault copies the buffer to storage and locks the stored log.
// R14 - Bit 0 set after a copy, cleared only by erase, inhibits transfers.
// R15 - Bit 1 set after restore, cleared only by a complete block read.
// R16 - Bit 1 blocks buffer updates; clear bit allows them.
// R17 - Status bits 7 to 2 read zero.
// R18 - Buffer refreshes after conversions only while bit 0 is clear.
// R19 - Fast option copies within 24 ms, else waits for both channels' readings.
// R20 - Log returned as a 255-byte block, one byte per request.
// R21 - Each conversion replaces a high-water or low-water value it passes.
`timescale 1ns/1ps
module flx_fault_log #(
  parameter int FAST_LOG_CYC = flx_pkg::FAST_LOG_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic byte_req,
  input wire logic clr_faults,
  input wire logic clr_page,
  input wire logic [1:0] chan_on,
  input wire logic adc_valid,
  input wire logic [1:0] adc_kind,
  input wire logic adc_chan,
  input wire logic [15:0] adc_value,
  input wire logic fault_latchoff,
  input wire logic log_enable,
  input wire logic fast_log,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic blk_done,
  output logic [7:0] log_status,
  output logic log_busy,
  output logic [1:0][15:0] vout_peak,
  output logic [1:0][15:0] vout_min,
  output logic [1:0][15:0] iout_peak,
  output logic [1:0][15:0] iout_min,
  output logic [1:0][15:0] temp_peak,
  output logic [1:0][15:0] temp_min,
  output logic [15:0] vin_min
);
  logic [1:0][15:0] vpk_r, vpk_nxt, vmn_r, vmn_nxt, ipk_r, ipk_nxt;
  logic [1:0][15:0] imn_r, imn_nxt, tpk_r, tpk_nxt, tmn_r, tmn_nxt;
  logic [15:0] vin_r, vin_nxt;
  logic [1:0] on_prev_r;
  logic [1:0] pre_ch;
  logic pre_any;
  flx_pkg::flx_state_e st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [1:0] seen_r, seen_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic trig;
  logic busy_r, busy_nxt;
  logic blk_act_r, blk_act_nxt, bq_r, bq_nxt;
  logic [7:0] bidx_r, bidx_nxt;
  logic [7:0] rdd_r, rdd_nxt;
  logic rdv_r, rdv_nxt, bdone_r, bdone_nxt;
  logic [15:0] smp_r, smp_nxt;
  logic [1:0] ph_r, ph_nxt;
  logic [6:0] ptr_r, ptr_nxt;
  logic [7:0] sw_r, sw_nxt;
  logic ref_ok;
  logic ram_we, nv_we;
  logic [7:0] ram_waddr, ram_wdata, ram_raddr, ram_q, nv_q, pre_byte;

  // Signed compare for two's-complement style codes, unsigned for output voltage
  function automatic logic f_gt(input logic [15:0] a, input logic [15:0] b, input logic sgn);
    f_gt = sgn ? ($signed(a) > $signed(b)) : (a > b);
  endfunction

  // Preset strobes from fault clear and off-to-on edges
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      pre_ch[c] = (clr_faults && (clr_page == c[0])) || (chan_on[c] && !on_prev_r[c]);
    end
    pre_any = clr_faults || (|(chan_on & ~on_prev_r));
  end

  // High-water and low-water tracking
  always_comb begin
    vpk_nxt = vpk_r;
    vmn_nxt = vmn_r;
    ipk_nxt = ipk_r;
    imn_nxt = imn_r;
    tpk_nxt = tpk_r;
    tmn_nxt = tmn_r;
    vin_nxt = vin_r;
    if (adc_valid) begin
      case (adc_kind)
        flx_pkg::KIND_VOUT: begin
          if (f_gt(adc_value, vpk_r[adc_chan], 1'b0)) vpk_nxt[adc_chan] = adc_value; // see R21
          if (f_gt(vmn_r[adc_chan], adc_value, 1'b0)) vmn_nxt[adc_chan] = adc_value; // see R21
        end
        flx_pkg::KIND_IOUT: begin
          if (f_gt(adc_value, ipk_r[adc_chan], 1'b1)) ipk_nxt[adc_chan] = adc_value; // see R21
          if (f_gt(imn_r[adc_chan], adc_value, 1'b1)) imn_nxt[adc_chan] = adc_value; // see R21
        end
        flx_pkg::KIND_TEMP: begin
          if (f_gt(adc_value, tpk_r[adc_chan], 1'b1)) tpk_nxt[adc_chan] = adc_value; // see R21
          if (f_gt(tmn_r[adc_chan], adc_value, 1'b1)) tmn_nxt[adc_chan] = adc_value; // see R21
        end
        default: begin
          if (f_gt(vin_r, adc_value, 1'b1)) vin_nxt = adc_value; // see R21
        end
      endcase
    end
    for (int c = 0; c < 2; c++) begin
      if (pre_ch[c]) begin
        vpk_nxt[c] = flx_pkg::VOUT_PEAK_RST; // see R1
        ipk_nxt[c] = flx_pkg::IOUT_PEAK_RST; // see R2
        tpk_nxt[c] = flx_pkg::TEMP_PEAK_RST; // see R3
        vmn_nxt[c] = flx_pkg::VOUT_MIN_RST; // see R5
        imn_nxt[c] = flx_pkg::IOUT_MIN_RST; // see R6
        tmn_nxt[c] = flx_pkg::TEMP_MIN_RST; // see R7
      end
    end
    if (pre_any) vin_nxt = flx_pkg::VIN_MIN_RST; // see R4
  end

  // Extremes registers with power-on presets
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vpk_r <= {2{flx_pkg::VOUT_PEAK_RST}}; // see R1
      ipk_r <= {2{flx_pkg::IOUT_PEAK_RST}}; // see R2
      tpk_r <= {2{flx_pkg::TEMP_PEAK_RST}}; // see R3
      vin_r <= flx_pkg::VIN_MIN_RST; // see R4
      vmn_r <= {2{flx_pkg::VOUT_MIN_RST}}; // see R5
      imn_r <= {2{flx_pkg::IOUT_MIN_RST}}; // see R6
      tmn_r <= {2{flx_pkg::TEMP_MIN_RST}}; // see R7
      on_prev_r <= 2'h0;
    end else begin
      vpk_r <= vpk_nxt;
      ipk_r <= ipk_nxt;
      tpk_r <= tpk_nxt;
      vin_r <= vin_nxt;
      vmn_r <= vmn_nxt;
      imn_r <= imn_nxt;
      tmn_r <= tmn_nxt;
      on_prev_r <= chan_on;
    end
  end

  // Transfer engine: store, restore, erase and the status bits
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    seen_nxt = seen_r;
    stat_nxt = stat_r;
    trig = log_enable && !stat_r[flx_pkg::ST_EEP_BIT] &&
           (fault_latchoff || (cmd_valid && cmd_code == flx_pkg::CMD_STORE)); // see R8, R13, R14
    case (st_r)
      flx_pkg::FLX_IDLE: begin
        cnt_nxt = 8'h00;
        seen_nxt = 2'h0;
        if (trig) begin
          st_nxt = fast_log ? flx_pkg::FLX_STORE : flx_pkg::FLX_WAIT; // see R19
        end else if (cmd_valid && cmd_code == flx_pkg::CMD_RESTORE) begin
          st_nxt = flx_pkg::FLX_RESTORE; // see R9
        end else if (cmd_valid && cmd_code == flx_pkg::CMD_ERASE) begin
          st_nxt = flx_pkg::FLX_ERASE; // see R10
        end
      end
      flx_pkg::FLX_WAIT: begin
        if (adc_valid) seen_nxt[adc_chan] = 1'b1;
        if (&seen_r) st_nxt = flx_pkg::FLX_STORE; // see R19
      end
      flx_pkg::FLX_STORE, flx_pkg::FLX_RESTORE, flx_pkg::FLX_ERASE: begin
        cnt_nxt = cnt_r + 8'h01;
        if (cnt_r == flx_pkg::COPY_END) begin
          st_nxt = flx_pkg::FLX_IDLE;
          if (st_r == flx_pkg::FLX_STORE) stat_nxt[flx_pkg::ST_EEP_BIT] = 1'b1; // see R13, R14
          if (st_r == flx_pkg::FLX_ERASE) stat_nxt[flx_pkg::ST_EEP_BIT] = 1'b0; // see R10, R14
        end
      end
      default: st_nxt = flx_pkg::FLX_IDLE;
    endcase
    busy_nxt = (st_nxt != flx_pkg::FLX_IDLE);
    // Completed block read releases the lock; a finishing restore sets it and wins
    if (bdone_nxt) stat_nxt[flx_pkg::ST_RAM_BIT] = 1'b0; // see R15
    if (st_r == flx_pkg::FLX_RESTORE && cnt_r == flx_pkg::COPY_END) begin
      stat_nxt[flx_pkg::ST_RAM_BIT] = 1'b1; // see R9, R15
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= flx_pkg::FLX_IDLE;
      cnt_r <= 8'h00;
      seen_r <= 2'h0;
      stat_r <= flx_pkg::STATUS_RST;
      busy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      seen_r <= seen_nxt;
      stat_r <= stat_nxt;
      busy_r <= busy_nxt;
    end
  end

  // Host reads: status byte and sequential log block
  always_comb begin
    blk_act_nxt = blk_act_r;
    bidx_nxt = bidx_r;
    bq_nxt = 1'b0;
    rdv_nxt = 1'b0;
    bdone_nxt = 1'b0;
    rdd_nxt = rdd_r;
    if (cmd_valid && cmd_code == flx_pkg::CMD_STATUS) begin
      rdv_nxt = 1'b1;
      rdd_nxt = {6'h00, stat_r}; // see R11, R17
    end else if (cmd_valid && cmd_code == flx_pkg::CMD_BLOCK && st_r == flx_pkg::FLX_IDLE) begin
      blk_act_nxt = 1'b1; // see R11
      bidx_nxt = 8'h00;
    end else if (byte_req && blk_act_r && !bq_r && !rdv_r) begin
      bq_nxt = 1'b1; // see R20
    end
    if (bq_r && blk_act_r) begin
      rdv_nxt = 1'b1;
      rdd_nxt = ram_q; // see R20
      bidx_nxt = bidx_r + 8'h01;
      if (bidx_r == flx_pkg::LAST_BYTE) begin
        blk_act_nxt = 1'b0;
        bdone_nxt = 1'b1; // see R15, R20
      end
    end
    if (st_r != flx_pkg::FLX_IDLE) blk_act_nxt = 1'b0;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      blk_act_r <= 1'b0;
      bidx_r <= 8'h00;
      bq_r <= 1'b0;
      rdd_r <= 8'h00;
      rdv_r <= 1'b0;
      bdone_r <= 1'b0;
    end else begin
      blk_act_r <= blk_act_nxt;
      bidx_r <= bidx_nxt;
      bq_r <= bq_nxt;
      rdd_r <= rdd_nxt;
      rdv_r <= rdv_nxt;
      bdone_r <= bdone_nxt;
    end
  end

  // Preamble byte chosen by the sweep pointer
  always_comb begin
    logic [7:0] off;
    logic [15:0] w;
    logic ch;
    off = 8'h00;
    w = 16'h0000;
    ch = (sw_r >= flx_pkg::CH1_BASE);
    pre_byte = 8'h00;
    if (sw_r == flx_pkg::POS_BYTE) begin
      pre_byte = {1'b0, ptr_r};
    end else if (sw_r == flx_pkg::VIN_MIN_LO || sw_r == flx_pkg::VIN_MIN_HI) begin
      pre_byte = (sw_r == flx_pkg::VIN_MIN_HI) ? vin_r[15:8] : vin_r[7:0];
    end else if ((sw_r >= flx_pkg::CH0_BASE && sw_r < flx_pkg::CH0_BASE + flx_pkg::CH_BYTES) ||
                 (sw_r >= flx_pkg::CH1_BASE && sw_r < flx_pkg::CH1_BASE + flx_pkg::CH_BYTES)) begin
      off = sw_r - (ch ? flx_pkg::CH1_BASE : flx_pkg::CH0_BASE);
      case (off[3:1])
        3'h0: w = vpk_r[ch];
        3'h1: w = vmn_r[ch];
        3'h2: w = tpk_r[ch];
        3'h3: w = tmn_r[ch];
        3'h4: w = ipk_r[ch];
        default: w = imn_r[ch];
      endcase
      pre_byte = off[0] ? w[15:8] : w[7:0];
    end
  end

  // Buffer refresh: conversions into the ring, extremes swept into the preamble
  always_comb begin
    ref_ok = !stat_r[flx_pkg::ST_EEP_BIT] && !stat_r[flx_pkg::ST_RAM_BIT] &&
             (st_r == flx_pkg::FLX_IDLE || st_r == flx_pkg::FLX_WAIT); // see R16, R18
    smp_nxt = smp_r;
    ph_nxt = ph_r;
    ptr_nxt = ptr_r;
    sw_nxt = sw_r;
    ram_we = 1'b0;
    ram_waddr = 8'h00;
    ram_wdata = 8'h00;
    if (st_r == flx_pkg::FLX_RESTORE && cnt_r != 8'h00) begin
      ram_we = 1'b1; // see R9
      ram_waddr = cnt_r - 8'h01;
      ram_wdata = nv_q;
    end else if (ref_ok && ph_r != 2'h0) begin
      ram_we = 1'b1; // see R12
      ram_waddr = flx_pkg::RING_BASE + {ptr_r, ph_r[1]};
      ram_wdata = ph_r[1] ? smp_r[15:8] : smp_r[7:0];
      ph_nxt = ph_r[1] ? 2'h0 : 2'h2;
      if (ph_r[1]) ptr_nxt = (ptr_r == flx_pkg::RING_LAST) ? 7'h00 : ptr_r + 7'h01;
    end else if (ref_ok) begin
      ram_we = 1'b1; // see R12
      ram_waddr = sw_r;
      ram_wdata = pre_byte;
      sw_nxt = (sw_r == flx_pkg::PRE_LAST) ? 8'h00 : sw_r + 8'h01;
    end
    if (!ref_ok) ph_nxt = 2'h0;
    if (adc_valid && ref_ok) begin
      smp_nxt = adc_value; // see R18
      ph_nxt = 2'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      smp_r <= 16'h0000;
      ph_r <= 2'h0;
      ptr_r <= 7'h00;
      sw_r <= 8'h00;
    end else begin
      smp_r <= smp_nxt;
      ph_r <= ph_nxt;
      ptr_r <= ptr_nxt;
      sw_r <= sw_nxt;
    end
  end

  // Buffer read port follows the engine counter while storing, else the block index; storage reads follow the counter
  assign ram_raddr = (st_r == flx_pkg::FLX_STORE) ? cnt_r : bidx_r;
  assign nv_we = (st_r == flx_pkg::FLX_STORE || st_r == flx_pkg::FLX_ERASE) && cnt_r != 8'h00;

  flx_mem #(.DEPTH(flx_pkg::LOG_BYTES), .AW(8)) u_ram (
    .sys_clk(sys_clk),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata),
    .raddr(ram_raddr),
    .rdata_r(ram_q)
  );

  // Nonvolatile stand-in; erase fills it with the blank value
  flx_mem #(.DEPTH(flx_pkg::LOG_BYTES), .AW(8)) u_nv (
    .sys_clk(sys_clk),
    .we(nv_we),
    .waddr(cnt_r - 8'h01),
    .wdata((st_r == flx_pkg::FLX_ERASE) ? flx_pkg::ERASE_VAL : ram_q),
    .raddr(cnt_r),
    .rdata_r(nv_q)
  );

  // Outputs straight from flops
  assign rd_data = rdd_r;
  assign rd_valid = rdv_r;
  assign blk_done = bdone_r;
  assign log_status = {6'h00, stat_r};
  assign log_busy = busy_r;
  assign vout_peak = vpk_r;
  assign vout_min = vmn_r;
  assign iout_peak = ipk_r;
  assign iout_min = imn_r;
  assign temp_peak = tpk_r;
  assign temp_min = tmn_r;
  assign vin_min = vin_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  int fast_wait_r;
  // Cycles from a fast-mode trigger until the engine is idle again
  always_ff @(posedge sys_clk) begin
    if (rst) fast_wait_r <= 0;
    else if (st_r == flx_pkg::FLX_IDLE) fast_wait_r <= (trig && fast_log) ? 1 : 0;
    else if (fast_wait_r != 0) fast_wait_r <= fast_wait_r + 1;
  end

  property p_vpk_preset; pre_ch[0] |=> vout_peak[0] == flx_pkg::VOUT_PEAK_RST; endproperty
  a_vpk_preset: assert property (p_vpk_preset) else $error("Vout peak not preset"); // see R1
  property p_vin_preset; pre_any |=> vin_min == flx_pkg::VIN_MIN_RST; endproperty
  a_vin_preset: assert property (p_vin_preset) else $error("Vin min not preset"); // see R4
  property p_imn_preset; pre_ch[1] |=> iout_min[1] == flx_pkg::IOUT_MIN_RST; endproperty
  a_imn_preset: assert property (p_imn_preset) else $error("Iout min not preset"); // see R6
  property p_peak_up;
    adc_valid && adc_kind == flx_pkg::KIND_VOUT && !adc_chan && !pre_ch[0] && adc_value > vout_peak[0]
      |=> vout_peak[0] == $past(adc_value);
  endproperty
  a_peak_up: assert property (p_peak_up) else $error("Vout peak missed a larger value"); // see R21
  property p_store_len; $rose(st_r == flx_pkg::FLX_STORE) |-> (st_r == flx_pkg::FLX_STORE) [*8]; endproperty
  a_store_len: assert property (p_store_len) else $error("Store ended early"); // see R8
  property p_eep_hold; $fell(log_status[0]) |-> $past(st_r) == flx_pkg::FLX_ERASE; endproperty
  a_eep_hold: assert property (p_eep_hold) else $error("Copied bit cleared without erase"); // see R14
  property p_eep_set; st_r == flx_pkg::FLX_STORE && cnt_r == flx_pkg::COPY_END |=> log_status[0]; endproperty
  a_eep_set: assert property (p_eep_set) else $error("Copied bit not set after store"); // see R13
  property p_ram_hold; $fell(log_status[1]) |-> blk_done; endproperty
  a_ram_hold: assert property (p_ram_hold) else $error("Lock cleared without full read"); // see R15
  property p_lock_blocks; log_status[1] && st_r != flx_pkg::FLX_RESTORE |-> !ram_we; endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("Locked buffer written"); // see R16
  property p_status_rd;
    cmd_valid && cmd_code == flx_pkg::CMD_STATUS |=> rd_valid && rd_data == {6'h00, $past(stat_r)};
  endproperty
  a_status_rd: assert property (p_status_rd) else $error("Status read wrong"); // see R11, R17
  property p_fast; fast_wait_r < FAST_LOG_CYC; endproperty
  a_fast: assert property (p_fast) else $error("Fast transfer late"); // see R19

  c_store: cover property (st_r == flx_pkg::FLX_STORE && cnt_r == flx_pkg::COPY_END);
  c_restore_read: cover property (log_status[1] ##1 blk_done);
  c_erase: cover property ($fell(log_status[0]));
endmodule

/* File: test/flx_host.sv */
// Host model: issues fault log commands and collects the answers.
// Assumes the fault log block on the same clock with registered answers.
`timescale 1ns/1ps
module flx_host (
  input wire logic sys_clk,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic blk_done,
  input wire logic log_busy,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic byte_req
);
  logic [7:0] blk [0:254];
  logic [7:0] st;
  int n_done;
  int hangs;
  // Idle bus at time zero
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    byte_req = 1'b0;
    hangs = 0;
  end
  // One-cycle command strobe; code is scrambled once unqualified
  task automatic issue(input logic [7:0] c);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c;
  endtask
  // Send-byte command, then wait for the engine to go idle
  task automatic send(input logic [7:0] c);
    int i;
    issue(c);
    repeat (2) @(posedge sys_clk);
    for (i = 0; i < 1000 && log_busy !== 1'b0; i++) @(posedge sys_clk);
    if (i == 1000) hangs++;
  endtask
  // Bounded wait for an answer strobe
  task automatic wait_ans();
    int i;
    for (i = 0; i < 8; i++) begin
      @(posedge sys_clk);
      if (rd_valid === 1'b1) break;
    end
    if (i == 8) hangs++;
  endtask
  // Read-byte of the status register
  task automatic get_status();
    issue(flx_pkg::CMD_STATUS);
    wait_ans();
    st = rd_data;
  endtask
  // Erase only when the buffer lock is clear
  task automatic erase();
    get_status();
    if (st[1] === 1'b0) send(flx_pkg::CMD_ERASE);
  endtask
  // Block read, one request per answered byte
  task automatic read_block();
    n_done = 0;
    issue(flx_pkg::CMD_BLOCK);
    for (int k = 0; k < 255; k++) begin
      byte_req <= 1'b1;
      @(posedge sys_clk);
      byte_req <= 1'b0;
      wait_ans();
      blk[k] = rd_data;
      if (blk_done === 1'b1) n_done += (k == 254) ? 1 : 100;
    end
  endtask
endmodule

/* File: test/fault_log_and_extremes_tb_top.sv */
// Testbench for the fault log and extremes block with a host model.
// Assumes the design package is compiled first.
`timescale 1ns/1ps
module fault_log_and_extremes_tb_top;
  logic sys_clk, rst, clr_faults, clr_page, adc_valid, adc_chan, fault_latchoff, log_enable, fast_log;
  logic cmd_valid, byte_req, rd_valid, blk_done, log_busy;
  logic [1:0] chan_on, adc_kind;
  logic [15:0] adc_value, vin_min;
  logic [7:0] cmd_code, rd_data, log_status;
  logic [1:0][15:0] vout_peak, vout_min, iout_peak, iout_min, temp_peak, temp_min;
  int mismatches, n_compared;
  flx_fault_log #(.FAST_LOG_CYC(300)) DUT (.sys_clk, .rst, .cmd_valid, .cmd_code, .byte_req, .clr_faults,
    .clr_page, .chan_on, .adc_valid, .adc_kind, .adc_chan, .adc_value, .fault_latchoff, .log_enable,
    .fast_log, .rd_data, .rd_valid, .blk_done, .log_status, .log_busy, .vout_peak, .vout_min,
    .iout_peak, .iout_min, .temp_peak, .temp_min, .vin_min);
  flx_host h (.sys_clk, .rd_valid, .rd_data, .blk_done, .log_busy, .cmd_valid, .cmd_code, .byte_req);
  // Clock, 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // Compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One conversion result, then let the extremes settle
  task automatic conv(input logic [1:0] k, input logic ch, input logic [15:0] v);
    @(posedge sys_clk);
    adc_valid <= 1'b1;
    adc_kind <= k;
    adc_chan <= ch;
    adc_value <= v;
    @(posedge sys_clk);
    adc_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  // Presets after reset and an all-zero status
  task automatic t_presets();
    for (int c = 0; c < 2; c++) begin
      chk(vout_peak[c], 16'hF800);
      chk(iout_peak[c], 16'h7C00);
      chk(temp_peak[c], 16'h7C00);
      chk(vout_min[c], 16'hFFFF);
      chk(iout_min[c], 16'h7BFF);
      chk(temp_min[c], 16'h7BFF);
    end
    chk(vin_min, 16'h7BFF);
    h.get_status();
    chk({8'h00, h.st}, 16'h0000);
  endtask
  // Extremes follow conversions, unsigned output voltage, signed others
  task automatic t_extremes();
    conv(2'h0, 1'b0, 16'hF900);
    conv(2'h0, 1'b0, 16'h1000);
    conv(2'h1, 1'b1, 16'h7D00);
    conv(2'h1, 1'b1, 16'h8000);
    conv(2'h2, 1'b0, 16'h7E00);
    conv(2'h2, 1'b0, 16'h0010);
    conv(2'h3, 1'b1, 16'h0100);
    chk(vout_peak[0], 16'hF900);
    chk(vout_min[0], 16'h1000);
    chk(iout_peak[1], 16'h7D00);
    chk(iout_min[1], 16'h8000);
    chk(temp_peak[0], 16'h7E00);
    chk(temp_min[0], 16'h0010);
    chk(vin_min, 16'h0100);
  endtask
  // Store, refused second store, restore with lock, then full read
  task automatic t_store_restore();
    h.send(flx_pkg::CMD_STORE);
    chk(log_status, 16'h0001);
    h.issue(flx_pkg::CMD_STORE);
    repeat (3) @(posedge sys_clk);
    chk(log_busy, 16'h0000);
    h.send(flx_pkg::CMD_RESTORE);
    h.get_status();
    chk(h.st, 16'h0003);
    conv(2'h0, 1'b0, 16'hFA00);
    h.read_block();
    chk(h.n_done, 16'h0001);
    chk({h.blk[12], h.blk[11]}, 16'hF900);
    chk({h.blk[14], h.blk[13]}, 16'h1000);
    h.get_status();
    chk(h.st, 16'h0001);
  endtask
  // Erase, then restored storage reads as all FF
  task automatic t_erase();
    int bad;
    bad = 0;
    h.erase();
    chk(log_status, 16'h0000);
    h.send(flx_pkg::CMD_RESTORE);
    h.read_block();
    for (int k = 0; k < 255; k++) if (h.blk[k] !== 8'hFF) bad++;
    chk(bad, 16'h0000);
    chk(log_status, 16'h0000);
  endtask
  // Store refused with logging disabled
  task automatic t_disabled();
    log_enable <= 1'b0;
    h.send(flx_pkg::CMD_STORE);
    chk(log_status, 16'h0000);
    log_enable <= 1'b1;
  endtask
  // Latch-off fault waits for both channels without fast option
  task automatic t_latchoff();
    int i;
    fast_log <= 1'b0;
    @(posedge sys_clk);
    fault_latchoff <= 1'b1;
    @(posedge sys_clk);
    fault_latchoff <= 1'b0;
    repeat (40) @(posedge sys_clk);
    chk(log_busy, 16'h0001);
    conv(2'h0, 1'b0, 16'h1000);
    conv(2'h0, 1'b1, 16'h1000);
    for (i = 0; i < 1000 && log_busy !== 1'b0; i++) @(posedge sys_clk);
    chk(log_status, 16'h0001);
    h.erase();
    fast_log <= 1'b1;
  endtask
  // Page clear and channel turn-on presets
  task automatic t_clears();
    clr_page <= 1'b1;
    clr_faults <= 1'b1;
    @(posedge sys_clk);
    clr_faults <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(iout_peak[1], 16'h7C00);
    chk(iout_min[1], 16'h7BFF);
    chk(temp_peak[0], 16'h7E00);
    conv(2'h3, 1'b0, 16'h0200);
    chan_on <= 2'b01;
    repeat (3) @(posedge sys_clk);
    chk(vout_peak[0], 16'hF800);
    chk(vout_min[0], 16'hFFFF);
    chk(temp_min[0], 16'h7BFF);
    chk(vin_min, 16'h7BFF);
  endtask
  // Summary and verdict, single exit
  task automatic give_verdict();
    mismatches += h.hangs;
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    mismatches = 0;
    n_compared = 0;
    rst = 1'b1;
    clr_faults = 1'b0;
    clr_page = 1'b0;
    chan_on = 2'b00;
    adc_valid = 1'b0;
    adc_kind = 2'h0;
    adc_chan = 1'b0;
    adc_value = 16'h0000;
    fault_latchoff = 1'b0;
    log_enable = 1'b1;
    fast_log = 1'b1;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_presets();
    t_extremes();
    t_store_restore();
    t_erase();
    t_disabled();
    t_latchoff();
    t_clears();
    give_verdict();
  end
  // Watchdog well beyond the expected run
  initial begin
    #3000000;
    mismatches++;
    give_verdict();
  end
endmodule
